// ===== smsp_port.sv
// Serial master/slave byte port with pin control, flags and receive FIFO.
//
// How it works
// R1: A data write during a transfer sets the write clash flag.
// R2: A clashing write is dropped; the running shift carries on untouched.
// R3: Clash detection works the same in master and slave role.
// R4: A data write outside a transfer loads the shift register directly.
// R5: Enabled master with select as input drops to slave when select goes low.
// R6: In enabled slave role the select pin is always an input.
// R7: Slave role makes clock and MOSI inputs; MISO follows its software setting.
// R8: Rate select bits are ignored in slave role; the remote clock is used.
// R9: The remote master keeps its clock at most a quarter of the core clock.
// R10: Status read followed by a data access clears the done flag.
// R11: The transfer interrupt is raised only while its enable bit is set.
// R12: All-zero polarity, phase and order bits give mode 0, MSB first.
// R13: Clock, MOSI and MISO are driven and data shifted only while enabled; a select output is driven even when disabled.
// R14: Master clock is the core clock divided by 4, 16, 64 or 128.
// R15: Role bit low selects slave, high selects master.
// R16: Multi-master software checks the role is still master before each transfer.
// R17: Both ends use equal polarity, phase and order settings.
// R18: Phase zero: idle first half cycle, sample leading edge, shift trailing edge.
// R19: Phase one: first leading edge presents MSB, sampling on trailing edges.
// R20: After eight clock pulses the done flag sets and the byte is buffered.
// R21: Slave phase zero presents the data MSB on MISO once select falls.
// R22: The same status read then data access also clears the clash flag.
`timescale 1ns/1ps
`default_nettype none
module smsp_port #(
  parameter int FIFO_DEPTH = smsp_pkg::RX_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Control bits.
  input wire logic serialPortEnable,
  input wire logic hostRoleSelect,
  input wire logic clockIdleLevel,
  input wire logic clockSamplePhase,
  input wire logic bitOrderSelect,
  input wire logic rateSelectLow,
  input wire logic rateSelectHigh,
  input wire logic xferIrqEnable,
  input wire logic ssIsOutput,
  input wire logic ssOutLevel,
  input wire logic misoOutputEnable,
  // Software data and status access.
  input wire logic txWrite,
  input wire logic [smsp_pkg::BYTE_W-1:0] txData,
  input wire logic statusRead,
  output logic rxValid,
  output logic [smsp_pkg::BYTE_W-1:0] rxData,
  input wire logic rxReady,
  // Status bits.
  output logic xferDoneFlag,
  output logic writeClashFlag,
  output logic hostRoleActive,
  output logic transferBusy,
  output logic xferIrq,
  // Serial clock pin.
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  // Master-out pin.
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  // Master-in pin.
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  // Active-low select pin.
  input wire logic selectInN,
  output logic selectOutN,
  output logic selectOe
);
  import smsp_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [3:0] pinMeta_reg;
  logic [3:0] pinSync_reg;
  wire logic [3:0] pinRaw = {misoIn, mosiIn, sckIn, selectInN};

  // Two flops on every pin input; only the second stage is used.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_reg <= PIN_SYNC_RESET;
      pinSync_reg <= PIN_SYNC_RESET;
    end else begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
    end
  end

  wire logic selectLow = ~pinSync_reg[SYNC_SS];

  // ************************************************************
  // Role selection
  // ************************************************************
  logic demoted_reg;

  // Master with a low select input drops to slave at once. [R5]
  wire logic modeFault = serialPortEnable & hostRoleSelect & ~ssIsOutput & selectLow;
  wire logic roleMaster = hostRoleSelect & ~demoted_reg & ~modeFault; // [R15]

  // The drop holds until software takes the role bit low.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      demoted_reg <= 1'b0;
    end else if (!hostRoleSelect) begin
      demoted_reg <= 1'b0;
    end else if (modeFault) begin
      demoted_reg <= 1'b1; // [R5]
    end
  end

  assign hostRoleActive = roleMaster;

  // ************************************************************
  // Master clock divider; only the master sequencer reads it
  // ************************************************************
  wire logic [6:0] halfPeriod = rateSelectHigh ? (rateSelectLow ? HALF_DIV128 : HALF_DIV64)
                                               : (rateSelectLow ? HALF_DIV16 : HALF_DIV4); // [R14] [R8]
  wire logic [6:0] halfLast = halfPeriod - 7'h01;

  // ************************************************************
  // Shift engine decode
  // ************************************************************
  smsp_master_t state_reg;
  logic [6:0] divCnt_reg;
  logic sckActive_reg;
  logic prevActive_reg;
  logic [BYTE_W-1:0] shiftReg_reg;
  logic [3:0] bitCnt_reg;
  logic rxBit_reg;
  logic doneFlag_reg;
  logic clashFlag_reg;
  logic armed_reg;
  smsp_fifo_if #(.WIDTH(BYTE_W)) rxFifo ();

  // Slave role: clock comes from the remote master only while selected.
  wire logic slaveSelected = serialPortEnable & ~roleMaster & selectLow;
  wire logic engineOn = serialPortEnable & (roleMaster ? (state_reg == MS_RUN) : slaveSelected); // [R13]
  wire logic activeNow = roleMaster ? sckActive_reg : (pinSync_reg[SYNC_SCK] ^ clockIdleLevel);
  wire logic leadEdge = engineOn & activeNow & ~prevActive_reg;
  wire logic trailEdge = engineOn & ~activeNow & prevActive_reg;
  wire logic inBit = roleMaster ? pinSync_reg[SYNC_MISO] : pinSync_reg[SYNC_MOSI];

  // Phase zero samples on leading and shifts on trailing edges. [R18]
  // Phase one shifts on later leading edges and samples on trailing. [R19]
  wire logic sampleEv = clockSamplePhase ? trailEdge : leadEdge; // [R17]
  wire logic byteDone = trailEdge & (bitCnt_reg == LAST_BIT); // [R20]
  wire logic shiftEv = clockSamplePhase ? ((leadEdge & (bitCnt_reg != BIT_CNT_RESET)) | byteDone) : trailEdge;
  wire logic shiftBit = (clockSamplePhase & trailEdge) ? inBit : rxBit_reg;
  wire logic [BYTE_W-1:0] shiftedWord = bitOrderSelect ? {shiftBit, shiftReg_reg[BYTE_W-1:1]}
                                                        : {shiftReg_reg[BYTE_W-2:0], shiftBit};
  wire logic txBit = bitOrderSelect ? shiftReg_reg[0] : shiftReg_reg[BYTE_W-1]; // [R12]

  // Busy comes from the sequencer state as master and from select, bit count and clock as slave. [R3]
  wire logic slaveBusy = slaveSelected & ((bitCnt_reg != BIT_CNT_RESET) | activeNow);
  wire logic busyNow = roleMaster ? (state_reg != MS_IDLE) : slaveBusy;
  wire logic clashSet = txWrite & busyNow; // [R1]
  wire logic txLoad = txWrite & ~busyNow; // [R4]

  // ************************************************************
  // Master sequencer
  // ************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= MS_IDLE;
      divCnt_reg <= DIV_CNT_RESET;
      sckActive_reg <= 1'b0;
    end else begin
      case (state_reg)
        MS_IDLE: begin
          if (txLoad & roleMaster & serialPortEnable) begin
            state_reg <= MS_WAIT_ROOM;
          end
        end
        MS_WAIT_ROOM: begin
          // Hold the clock until the receive FIFO has room for the byte.
          if (!roleMaster || !serialPortEnable) begin
            state_reg <= MS_IDLE;
          end else if (rxFifo.inReady) begin
            state_reg <= MS_RUN;
            divCnt_reg <= DIV_CNT_RESET;
            sckActive_reg <= clockSamplePhase; // [R19]
          end
        end
        MS_RUN: begin
          if (!roleMaster || !serialPortEnable || byteDone) begin
            state_reg <= MS_IDLE;
            sckActive_reg <= 1'b0;
          end else if (divCnt_reg == halfLast) begin
            divCnt_reg <= DIV_CNT_RESET;
            sckActive_reg <= ~sckActive_reg; // [R14]
          end else begin
            divCnt_reg <= divCnt_reg + 7'h01;
          end
        end
        default: begin
          state_reg <= MS_IDLE;
          sckActive_reg <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Shift register, bit counter and sampled bit
  // ************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shiftReg_reg <= SHIFT_RESET;
      prevActive_reg <= 1'b0;
    end else begin
      prevActive_reg <= engineOn & activeNow;
      if (txLoad) begin
        shiftReg_reg <= txData; // [R4]
      end else if (shiftEv) begin
        shiftReg_reg <= shiftedWord; // [R2]
      end
    end
  end

  // Counting restarts whenever the engine is off or a byte completes.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_reg <= BIT_CNT_RESET;
      rxBit_reg <= 1'b0;
    end else begin
      if (!engineOn || byteDone) begin
        bitCnt_reg <= BIT_CNT_RESET;
      end else if (trailEdge) begin
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end
      if (sampleEv) begin
        rxBit_reg <= inBit;
      end
    end
  end

  // ************************************************************
  // Status flags; a new event wins over a clear in the same cycle
  // ************************************************************
  wire logic dataAccess = txWrite | (rxValid & rxReady);
  wire logic clearReq = armed_reg & dataAccess; // [R10] [R22]

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      doneFlag_reg <= 1'b0;
      clashFlag_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      doneFlag_reg <= byteDone | (doneFlag_reg & ~clearReq); // [R20] [R10]
      clashFlag_reg <= clashSet | (clashFlag_reg & ~clearReq); // [R1] [R22]
      if (clearReq) begin
        armed_reg <= 1'b0;
      end else if (statusRead && (doneFlag_reg || clashFlag_reg)) begin
        armed_reg <= 1'b1;
      end
    end
  end

  assign xferDoneFlag = doneFlag_reg;
  assign writeClashFlag = clashFlag_reg;
  assign transferBusy = busyNow;
  assign xferIrq = xferIrqEnable & doneFlag_reg; // [R11]

  // ************************************************************
  // Receive FIFO; a slave byte is lost if it arrives when full
  // ************************************************************
  assign rxFifo.inData = shiftedWord;
  assign rxFifo.inValid = byteDone; // [R20]
  assign rxFifo.outReady = rxReady;
  assign rxValid = rxFifo.outValid;
  assign rxData = rxFifo.outData;

  smsp_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rxFifo (
    .clock(clock),
    .reset_n(reset_n),
    .port(rxFifo.fifo)
  );

  // ************************************************************
  // Pin drivers
  // ************************************************************
  assign sckOut = clockIdleLevel ^ sckActive_reg;
  assign sckOe = serialPortEnable & roleMaster; // [R7] [R13]
  assign mosiOut = txBit;
  assign mosiOe = serialPortEnable & roleMaster; // [R7] [R13]
  assign misoOut = txBit; // [R21]
  assign misoOe = serialPortEnable & ~roleMaster & misoOutputEnable; // [R7]
  assign selectOutN = ssOutLevel;
  assign selectOe = ssIsOutput & (~serialPortEnable | roleMaster); // [R6]

  // ************************************************************
  // Checks
  // ************************************************************
  property p_clash_sets;
    @(posedge clock) disable iff (!reset_n) txWrite && busyNow |=> writeClashFlag;
  endproperty
  a_clash_sets: assert property (p_clash_sets) else $error("Clash flag missed a busy write."); // [R1]

  property p_clash_drops;
    @(posedge clock) disable iff (!reset_n)
      txWrite && busyNow && !shiftEv |=> shiftReg_reg == $past(shiftReg_reg);
  endproperty
  a_clash_drops: assert property (p_clash_drops) else $error("Clashing write altered the shift data."); // [R2]

  property p_idle_load;
    @(posedge clock) disable iff (!reset_n) txWrite && !busyNow |=> shiftReg_reg == $past(txData);
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("Idle write did not load the shift data."); // [R4]

  property p_mode_fault;
    @(posedge clock) disable iff (!reset_n)
      serialPortEnable && hostRoleSelect && !ssIsOutput && selectLow |-> !hostRoleActive ##1 !hostRoleActive;
  endproperty
  a_mode_fault: assert property (p_mode_fault) else $error("Low select did not force slave role."); // [R5]

  property p_slave_pins;
    @(posedge clock) disable iff (!reset_n)
      serialPortEnable && !hostRoleActive |-> !sckOe && !mosiOe && !selectOe && (misoOe == misoOutputEnable);
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("Slave pin directions are wrong."); // [R7]

  property p_disabled_quiet;
    @(posedge clock) disable iff (!reset_n) !serialPortEnable |-> !sckOe && !mosiOe && !misoOe && !shiftEv;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("Disabled port drove or shifted."); // [R13]

  property p_irq_gate;
    @(posedge clock) disable iff (!reset_n) xferIrq |-> xferIrqEnable && xferDoneFlag;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("Interrupt raised without enable."); // [R11]

  property p_done_after_eight;
    @(posedge clock) disable iff (!reset_n) trailEdge && bitCnt_reg == 4'h7 |=> xferDoneFlag && rxValid;
  endproperty
  a_done_after_eight: assert property (p_done_after_eight) else $error("Eighth pulse did not finish the byte."); // [R20]

  property p_flag_clear;
    @(posedge clock) disable iff (!reset_n) armed_reg && dataAccess && !byteDone && !clashSet |=>
      !xferDoneFlag && !writeClashFlag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Status then data access left a flag set."); // [R10] [R22]

  property p_div4_high;
    @(posedge clock) disable iff (!reset_n)
      $rose(sckActive_reg) && state_reg == MS_RUN && $past(state_reg) == MS_RUN && !rateSelectHigh && !rateSelectLow
      |-> sckActive_reg [*2];
  endproperty
  a_div4_high: assert property (p_div4_high) else $error("Divide-by-four half period is not two cycles."); // [R14]

endmodule // smsp_port
`default_nettype wire

// ===== smsp_pkg.sv
// Shared constants and types for the serial master/slave port.
package smsp_pkg;

  // ************************************************************
  // Data and counting
  // ************************************************************
  localparam int BYTE_W = 8;
  localparam int RX_FIFO_DEPTH = 16;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  // ************************************************************
  // Master clock divider, in core clock cycles per half period
  // ************************************************************
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [6:0] DIV_CNT_RESET = 7'h00;

  // ************************************************************
  // Pin synchroniser layout and reset value (select idles high)
  // ************************************************************
  localparam int SYNC_SS = 0;
  localparam int SYNC_SCK = 1;
  localparam int SYNC_MOSI = 2;
  localparam int SYNC_MISO = 3;
  localparam logic [3:0] PIN_SYNC_RESET = 4'h1;

  // ************************************************************
  // Master sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    MS_IDLE,
    MS_WAIT_ROOM,
    MS_RUN
  } smsp_master_t;

endpackage

// ===== smsp_fifo_if.sv
// Valid/ready bundle between the port engine and its receive FIFO.
`timescale 1ns/1ps
`default_nettype none
interface smsp_fifo_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] inData;
  logic inValid;
  logic inReady;
  logic [WIDTH-1:0] outData;
  logic outValid;
  logic outReady;

  modport fifo (input inData, input inValid, input outReady, output inReady, output outData, output outValid);
  modport user (output inData, output inValid, output outReady, input inReady, input outData, input outValid);
endinterface
`default_nettype wire

// ===== smsp_fifo.sv
// Receive buffer FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module smsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Both sides of the buffer.
  smsp_fifo_if.fifo port
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;

  // ************************************************************
  // Handshake decode
  // ************************************************************
  wire logic push = port.inValid & port.inReady;
  wire logic pop = port.outValid & port.outReady;
  assign port.inReady = (count_reg != (PW + 1)'(DEPTH));
  assign port.outValid = (count_reg != '0);
  assign port.outData = mem[rdPtr_reg];

  // Storage array; no reset needed on the data itself.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_reg] <= port.inData;
    end
  end

  // Pointers wrap at the depth and the count tracks occupancy.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
endmodule // smsp_fifo
`default_nettype wire

// ===== smsp_remote_model.sv
// Behavioural remote serial device: a slave for master tests, a master for slave tests.
`timescale 1ns/1ps
`default_nettype none
module smsp_remote_model #(
  parameter int HALF_NS = 500
) (
  // Role and frame format.
  input wire logic isSlave,
  input wire logic clock_idle_level,
  input wire logic clock_sample_phase,
  input wire logic lsbFirst,
  // Resolved wires.
  input wire logic sck,
  input wire logic mosi,
  input wire logic selN,
  input wire logic misoIn,
  // Lines driven by the model.
  output logic sckM,
  output logic mosiM,
  output logic selM,
  output logic misoS
);
  // ************************************************************
  // Shift state
  // ************************************************************
  logic [7:0] txByte = 8'h00;
  logic [7:0] rxS = 8'h00;
  logic [7:0] rxM = 8'h00;
  int idx = 0;

  // Picks bit i of a byte in frame order.
  function automatic logic pick(input logic [7:0] b, input int i);
    return lsbFirst ? b[i] : b[7-i];
  endfunction

  // Shifts one received bit in, in frame order.
  function automatic logic [7:0] shin(input logic [7:0] r, input logic d);
    return lsbFirst ? {d, r[7:1]} : {r[6:0], d};
  endfunction

  // Idle lines: clock at rest, select high.
  initial begin
    sckM = 1'b0;
    mosiM = 1'b0;
    selM = 1'b1;
    misoS = 1'b0;
  end

  // Selection starts a frame; phase zero shows the first bit at once.
  always @(negedge selN) if (isSlave) begin
    idx = 0;
    if (!clock_sample_phase) misoS = pick(txByte, 0);
  end

  // A released MISO shows the inverse of its last bit, not a held value.
  always @(posedge selN) if (isSlave) misoS = ~misoS;

  // Sample on one edge and shift on the other, chosen by the phase.
  always @(sck) if (isSlave && !selN) begin
    if ((sck != clock_idle_level) ^ clock_sample_phase) rxS = shin(rxS, mosi);
    else begin
      if (!clock_sample_phase) idx++;
      if (idx < 8) misoS = pick(txByte, idx);
      if (clock_sample_phase) idx++;
    end
  end

  // Remote master frame; the half period keeps the clock at most a quarter of the core clock.
  task automatic masterXfer(input logic [7:0] b);
    sckM = clock_idle_level;
    selM = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!clock_sample_phase) mosiM = pick(b, i);
      #(HALF_NS) sckM = ~clock_idle_level;
      if (clock_sample_phase) mosiM = pick(b, i);
      else rxM = shin(rxM, misoIn);
      #(HALF_NS) sckM = clock_idle_level;
      if (clock_sample_phase) rxM = shin(rxM, misoIn);
    end
    #(HALF_NS) selM = 1'b1;
    mosiM = ~mosiM;
  endtask
endmodule // smsp_remote_model
`default_nettype wire

// ===== test_spi_master_slave_port.sv
// Self-checking bench for the serial master/slave port against a remote model.
`timescale 1ns/1ps
`default_nettype none
module test_spi_master_slave_port;
  import smsp_pkg::*;
  // ************************************************************
  // Stimulus, wires and counters
  // ************************************************************
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic en = 0, role = 0, clock_idle_level = 0, clock_sample_phase = 0, lsb = 0, rLo = 0, rHi = 0, irqEn = 0;
  logic ssOut = 0, ssLvl = 1, misoEn = 0, txWrite = 0, statusRead = 0, rxReady = 0, isSlave = 1;
  logic [7:0] txData = 8'h00;
  logic [7:0] rxData;
  logic rxValid, doneF, clashF, roleAct, busy, irq;
  logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, selOut, selOe, sckM, mosiM, selM, misoS;
  logic [6:0] halfTab [4] = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, HALF_DIV128};
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  // Each wire level comes from whichever party enables its driver.
  wire logic sckW = sckOe ? sckOut : sckM;
  wire logic mosiW = mosiOe ? mosiOut : mosiM;
  wire logic misoW = misoOe ? misoOut : misoS;
  wire logic selW = selOe ? selOut : selM;

  smsp_port DUT (.clock(clock), .reset_n(reset_n), .serialPortEnable(en), .hostRoleSelect(role),
    .clockIdleLevel(clock_idle_level), .clockSamplePhase(clock_sample_phase), .bitOrderSelect(lsb), .rateSelectLow(rLo),
    .rateSelectHigh(rHi), .xferIrqEnable(irqEn), .ssIsOutput(ssOut), .ssOutLevel(ssLvl),
    .misoOutputEnable(misoEn), .txWrite(txWrite), .txData(txData), .statusRead(statusRead),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .xferDoneFlag(doneF), .writeClashFlag(clashF),
    .hostRoleActive(roleAct), .transferBusy(busy), .xferIrq(irq), .sckIn(sckW), .sckOut(sckOut),
    .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoW), .misoOut(misoOut),
    .misoOe(misoOe), .selectInN(selW), .selectOutN(selOut), .selectOe(selOe));

  smsp_remote_model remote (.isSlave(isSlave), .clock_idle_level(clock_idle_level), .clock_sample_phase(clock_sample_phase), .lsbFirst(lsb), .sck(sckW),
    .mosi(mosiW), .selN(selW), .misoIn(misoW), .sckM(sckM), .mosiM(mosiM), .selM(selM), .misoS(misoS));

  // Core clock of 100 ns and a cycle ceiling against hangs.
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  // Waits n edges and steps just past the last one.
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Compares one result and counts it.
  task automatic checkVal(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Status read then a receive pop clears both flags.
  task automatic clearFlags();
    statusRead = 1;
    tick();
    statusRead = 0;
    rxReady = 1;
    tick();
    rxReady = 0;
    tick();
    checkVal("doneFlag", 0, doneF);
    checkVal("clashFlag", 0, clashF);
  endtask

  // One master frame, optionally hit by a clashing write, timed by active clock cycles.
  task automatic masterXfer(input logic [7:0] tx, input logic [7:0] rem, input logic [6:0] half,
                            input logic clash);
    int act;
    act = 0;
    checkVal("hostRole", 1, roleAct);
    remote.txByte = rem;
    ssLvl = 0;
    tick(2);
    txData = tx;
    txWrite = 1;
    tick();
    txWrite = 0;
    txData = ~tx;
    checkVal("busy", 1, busy);
    // The clashing write lands early in the frame, four cycles after the load, while every active cycle is still counted.
    for (int i = 0; i < 3000 && doneF !== 1'b1; i++) begin
      txWrite = clash && i == 3;
      tick();
      if (sckOut !== clock_idle_level) act++;
    end
    checkVal("clashFlag", clash, clashF);
    checkVal("sckActive", 16'(half) * 16'd8, act[15:0]);
    checkVal("doneFlag", 1, doneF);
    checkVal("rxData", rem, rxData);
    checkVal("remoteRx", tx, remote.rxS);
    checkVal("irq", irqEn, irq);
    ssLvl = 1;
    clearFlags();
  endtask

  // Remote master frame into the slave port, with a clashing write in mid-frame.
  task automatic slaveXfer();
    isSlave = 0;
    {clock_idle_level, clock_sample_phase, lsb, rHi, rLo} = 5'h03;
    misoEn = 1;
    ssOut = 1;
    tick(3);
    checkVal("sckOe", 0, sckOe);
    checkVal("mosiOe", 0, mosiOe);
    checkVal("misoOe", 1, misoOe);
    checkVal("selectOe", 0, selOe);
    txData = 8'h5a;
    txWrite = 1;
    tick();
    txWrite = 0;
    fork
      remote.masterXfer(8'hc3);
      begin
        tick(30);
        txData = 8'hff;
        txWrite = 1;
        tick();
        txWrite = 0;
      end
    join
    tick(5);
    checkVal("clashFlag", 1, clashF);
    checkVal("doneFlag", 1, doneF);
    checkVal("rxData", 8'hc3, rxData);
    checkVal("remoteRx", 8'h5a, remote.rxM);
    clearFlags();
    misoEn = 0;
    tick();
    checkVal("misoOe", 0, misoOe);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence: reset, disabled pins, all master modes and rates, mode fault, slave role.
  initial begin
    tick(10);
    reset_n = 1;
    tick();
    checkVal("sckOe", 0, sckOe);
    checkVal("mosiOe", 0, mosiOe);
    en = 1;
    role = 1;
    ssOut = 1;
    tick(3);
    checkVal("hostRole", 1, roleAct);
    checkVal("sckOe", 1, sckOe);
    for (int m = 0; m < 4; m++) begin
      {clock_idle_level, clock_sample_phase} = m[1:0];
      lsb = m[0];
      {rHi, rLo} = m[1:0];
      irqEn = m[1];
      tick(2);
      masterXfer(8'ha5 ^ 8'(m), 8'h3c ^ 8'(m * 17), halfTab[m], m == 1);
    end
    {clock_idle_level, clock_sample_phase, lsb} = 3'h0;
    ssOut = 0;
    tick(2);
    remote.selM = 0;
    tick(5);
    checkVal("hostRole", 0, roleAct);
    checkVal("sckOe", 0, sckOe);
    role = 0;
    remote.selM = 1;
    tick(5);
    slaveXfer();
    final_report();
  end
endmodule // test_spi_master_slave_port
`default_nettype wire
